// ===== rtl/srs_pkg.sv
package srs_pkg;

  // Clock and start-up delay.
  localparam int unsigned SRS_CLK_FREQ_MHZ   = 200;
  localparam int unsigned SRS_READY_DELAY_US = 1500000;
  localparam int unsigned SRS_READY_CYCLES   = SRS_READY_DELAY_US * SRS_CLK_FREQ_MHZ;
  localparam int unsigned SRS_PWM_DELAY_US   = 1500000;
  localparam int unsigned SRS_PWM_CYCLES     = SRS_PWM_DELAY_US * SRS_CLK_FREQ_MHZ;

  // Default widths.
  localparam int unsigned SRS_SPEED_W = 16;
  localparam int unsigned SRS_GEAR_W  = 16;
  localparam int unsigned SRS_CNT_W   = 32;
  localparam int unsigned SRS_SYNC_W  = 5;

  // Positions of the synchronised pins in the device sync vector.
  localparam int unsigned SRS_SYN_CTRL = 4;
  localparam int unsigned SRS_SYN_MAIN = 3;
  localparam int unsigned SRS_SYN_ALM  = 2;
  localparam int unsigned SRS_SYN_FWD  = 1;
  localparam int unsigned SRS_SYN_REV  = 0;

  // Values after reset.
  localparam logic SRS_INHIBIT_RST = 1'b1;
  localparam logic SRS_ENABLE_RST  = 1'b0;

  typedef enum logic [1:0] {
    SRS_MODE_POS   = 2'h0,
    SRS_MODE_SPD   = 2'h1,
    SRS_MODE_TRIAL = 2'h2,
    SRS_MODE_JOG   = 2'h3
  } srs_mode_t;

  typedef enum logic [1:0] {
    SRS_ST_OFF    = 2'h0,
    SRS_ST_CHARGE = 2'h1,
    SRS_ST_READY  = 2'h2,
    SRS_ST_RUN    = 2'h3
  } srs_state_t;

endpackage

// ===== rtl/srs_if.sv
`timescale 1ns/1ps
interface srs_if;
  // Controller to drive.
  logic drive_enable_in;
  logic ccw_inhibit_in;
  logic cw_inhibit_in;
  logic speed_select_low;
  logic speed_select_high;
  logic cmd_pulse;
  logic cmd_dir;
  // Drive to controller.
  logic servo_ready_out;
  logic alarm_out;

  modport dev (
    input  drive_enable_in, ccw_inhibit_in, cw_inhibit_in,
    input  speed_select_low, speed_select_high, cmd_pulse, cmd_dir,
    output servo_ready_out, alarm_out
  );

  modport ctl (
    output drive_enable_in, ccw_inhibit_in, cw_inhibit_in,
    output speed_select_low, speed_select_high, cmd_pulse, cmd_dir,
    input  servo_ready_out, alarm_out
  );
endinterface

// ===== rtl/srs_drive.sv
`timescale 1ns/1ps
module srs_drive
  import srs_pkg::*;
#(
  parameter int unsigned READY_CYCLES = SRS_READY_CYCLES,
  parameter int unsigned SPEED_W      = SRS_SPEED_W,
  parameter int unsigned GEAR_W       = SRS_GEAR_W
)(
  // Clock and reset
  input  wire logic                      ref_clk,
  input  wire logic                      rst,
  // Controller link
  srs_if.dev                             link,
  // Power and fault pins
  input  wire logic                      ctrl_power_ok,
  input  wire logic                      main_power_ok,
  input  wire logic                      alarm_in,
  // Stored settings and keys
  input  wire srs_mode_t                 mode_sel,
  input  wire logic [4*SPEED_W-1:0]      speed_presets,
  input  wire logic signed [SPEED_W-1:0] trial_speed,
  input  wire logic signed [SPEED_W-1:0] jog_speed,
  input  wire logic                      jog_fwd_key,
  input  wire logic                      jog_rev_key,
  input  wire logic [GEAR_W-1:0]         gear_num,
  input  wire logic [GEAR_W-1:0]         gear_den,
  // Power stage
  output logic                           pwm_enable,
  output logic signed [SPEED_W-1:0]      speed_cmd,
  output logic                           pos_step,
  output logic                           pos_dir,
  output logic                           alarm_active
);

  if (READY_CYCLES < 2 || READY_CYCLES >= 32'hffff_ffff) begin : g_bad_delay
    $error("READY_CYCLES out of range");
  end
  if (SPEED_W < 2 || GEAR_W < 1) begin : g_bad_width
    $error("SPEED_W or GEAR_W too small");
  end

  typedef struct packed {
    logic [SRS_SYNC_W-1:0]       meta;
    logic [SRS_SYNC_W-1:0]       sync;
    srs_state_t                  state;
    logic [SRS_CNT_W-1:0]        cnt;
    logic                        fault;
    logic                        ready;
    logic                        pwm;
    logic signed [SPEED_W-1:0]   speed;
    logic                        step;
    logic                        dir;
    logic [GEAR_W+1:0]           acc;
  } srs_dev_t;

  localparam logic [SRS_CNT_W-1:0] LAST_CNT = SRS_CNT_W'(READY_CYCLES - 1);

  srs_dev_t q;
  srs_dev_t next_q;

  logic                      ctrl_ok;
  logic                      main_ok;
  logic                      alm;
  logic                      powered;
  logic signed [SPEED_W-1:0] want;
  logic [GEAR_W+1:0]         sum;
  logic                      dir_ok;

  always_comb
  begin
    next_q      = q;
    next_q.meta = {ctrl_power_ok, main_power_ok, alarm_in, jog_fwd_key, jog_rev_key};
    next_q.sync = q.meta;
    ctrl_ok     = q.sync[SRS_SYN_CTRL];
    main_ok     = q.sync[SRS_SYN_MAIN];
    alm         = q.sync[SRS_SYN_ALM];
    powered     = ctrl_ok && main_ok;
    next_q.step = 1'b0;
    want        = '0;
    sum         = q.acc;
    dir_ok      = 1'b0;

    // A new alarm wins over its release in the same cycle.
    if (alm)
    begin
      next_q.fault = 1'b1;
    end
    else if (q.fault && !link.drive_enable_in)
    begin
      next_q.fault = 1'b0;
    end

    case (q.state)
      SRS_ST_OFF:
      begin
        next_q.cnt = '0;
        if (powered)
        begin
          next_q.state = SRS_ST_CHARGE;
        end
      end
      SRS_ST_CHARGE:
      begin
        if (!powered)
        begin
          next_q.state = SRS_ST_OFF;
          next_q.cnt   = '0;
        end
        else if (q.cnt == LAST_CNT)
        begin
          next_q.state = SRS_ST_READY;
        end
        else
        begin
          next_q.cnt = q.cnt + SRS_CNT_W'(1);
        end
      end
      SRS_ST_READY:
      begin
        if (!powered)
        begin
          next_q.state = SRS_ST_OFF;
        end
        else if (link.drive_enable_in && !alm && !q.fault)
        begin
          next_q.state = SRS_ST_RUN;
        end
      end
      SRS_ST_RUN:
      begin
        if (!powered)
        begin
          next_q.state = SRS_ST_OFF;
        end
        else if (!link.drive_enable_in || alm || q.fault)
        begin
          next_q.state = SRS_ST_READY;
        end
      end
      default:
      begin
        next_q.state = SRS_ST_OFF;
        next_q.cnt   = '0;
      end
    endcase

    next_q.pwm   = (next_q.state == SRS_ST_RUN);
    next_q.ready = (next_q.state == SRS_ST_READY || next_q.state == SRS_ST_RUN) && !next_q.fault;

    case (mode_sel)
      SRS_MODE_SPD:
      begin
        want = speed_presets[{link.speed_select_high, link.speed_select_low}*SPEED_W +: SPEED_W];
      end
      SRS_MODE_TRIAL:
      begin
        want = trial_speed;
      end
      SRS_MODE_JOG:
      begin
        if (q.sync[SRS_SYN_FWD])
        begin
          want = jog_speed;
        end
        else if (q.sync[SRS_SYN_REV])
        begin
          want = -jog_speed;
        end
        else
        begin
          want = '0;
        end
      end
      default:
      begin
        want = '0;
      end
    endcase

    // Positive speed turns counter-clockwise; an inhibit input that is off blocks its direction.
    if (!next_q.pwm || (want > 0 && !link.ccw_inhibit_in) || (want < 0 && !link.cw_inhibit_in))
    begin
      want = '0;
    end
    next_q.speed = want;

    // Command pulses add the numerator; each step due subtracts the denominator, even one that an inhibit blocks.
    if (next_q.pwm && mode_sel == SRS_MODE_POS)
    begin
      if (link.cmd_pulse)
      begin
        sum        = q.acc + (GEAR_W+2)'(gear_num);
        next_q.dir = link.cmd_dir;
      end
      dir_ok = next_q.dir ? link.cw_inhibit_in : link.ccw_inhibit_in;
      if (gear_den != '0 && sum >= (GEAR_W+2)'(gear_den))
      begin
        next_q.step = dir_ok;
        sum         = sum - (GEAR_W+2)'(gear_den);
      end
      next_q.acc = sum;
    end
    else
    begin
      next_q.acc = '0;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      q       <= '0;
      q.state <= SRS_ST_OFF;
    end
    else
    begin
      q <= next_q;
    end
  end

  assign link.servo_ready_out = q.ready;
  assign link.alarm_out       = q.fault;
  assign pwm_enable           = q.pwm;
  assign speed_cmd            = q.speed;
  assign pos_step             = q.step;
  assign pos_dir              = q.dir;
  assign alarm_active         = q.fault;

endmodule // srs_drive

// ===== rtl/srs_ctl.sv
`timescale 1ns/1ps
module srs_ctl
  import srs_pkg::*;
(
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst,
  // Drive link
  srs_if.ctl              link,
  // User requests
  input  wire logic       power_req,
  input  wire logic       run_req,
  input  wire logic       ccw_stop_req,
  input  wire logic       cw_stop_req,
  input  wire logic [1:0] speed_sel,
  input  wire logic       step_req,
  input  wire logic       step_dir,
  // Power switches and status
  output logic            ctrl_power_on,
  output logic            main_power_on,
  output logic            restart_blocked
);

  typedef struct packed {
    logic       ctrl;
    logic       main;
    logic       lock;
    logic       en;
    logic       ccw;
    logic       cw;
    logic [1:0] sel;
    logic       pulse;
    logic       dir;
  } srs_ctl_t;

  srs_ctl_t q;
  srs_ctl_t next_q;

  always_comb
  begin
    next_q = q;
    // Main power follows control power by a cycle and drops first.
    next_q.ctrl = power_req || q.main;
    next_q.main = power_req && q.ctrl;
    if (link.alarm_out)
    begin
      next_q.lock = 1'b1;
    end
    else if (q.lock && !run_req)
    begin
      next_q.lock = 1'b0;
    end
    next_q.en    = run_req && q.main && link.servo_ready_out && !link.alarm_out && !next_q.lock;
    next_q.ccw   = !ccw_stop_req;
    next_q.cw    = !cw_stop_req;
    next_q.sel   = speed_sel;
    next_q.pulse = step_req && q.en;
    next_q.dir   = step_dir;
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      q     <= '0;
      q.en  <= SRS_ENABLE_RST;
      q.ccw <= SRS_INHIBIT_RST;
      q.cw  <= SRS_INHIBIT_RST;
    end
    else
    begin
      q <= next_q;
    end
  end

  assign link.drive_enable_in   = q.en;
  assign link.ccw_inhibit_in    = q.ccw;
  assign link.cw_inhibit_in     = q.cw;
  assign link.speed_select_low  = q.sel[0];
  assign link.speed_select_high = q.sel[1];
  assign link.cmd_pulse         = q.pulse;
  assign link.cmd_dir           = q.dir;
  assign ctrl_power_on          = q.ctrl;
  assign main_power_on          = q.main;
  assign restart_blocked        = q.lock;

endmodule // srs_ctl

// ===== dv/srs_assertions.sv
`timescale 1ns/1ps
module srs_assertions
  import srs_pkg::*;
#(
  parameter int unsigned READY_CYCLES = 20
)(
  // Clock and reset
  input wire logic                          ref_clk,
  input wire logic                          rst,
  // Link and drive pins
  input wire logic                          drive_enable_in,
  input wire logic                          servo_ready_out,
  input wire logic                          alarm_out,
  input wire logic                          main_power_ok,
  input wire logic                          pwm_enable,
  input wire logic                          pos_step,
  input wire srs_mode_t                     mode_sel,
  input wire logic signed [SRS_SPEED_W-1:0] speed_cmd
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  ready_delay_a: assert property ($rose(servo_ready_out) |-> $past(main_power_ok, READY_CYCLES))
    else $error("Ready rose before the main power delay.");
  ready_loss_a: assert property (!main_power_ok |-> ##[0:4] !servo_ready_out)
    else $error("Ready stayed up without main power.");
  pwm_rise_a: assert property ($rose(pwm_enable) |-> $past(drive_enable_in) && $past(servo_ready_out))
    else $error("Power stage started without ready and enable.");
  pwm_on_a: assert property (servo_ready_out && drive_enable_in && !alarm_out
    |=> pwm_enable || alarm_out || !servo_ready_out)
    else $error("Power stage did not start.");
  pwm_off_a: assert property (!drive_enable_in |=> !pwm_enable)
    else $error("Power stage stayed on without enable.");
  alarm_off_a: assert property (alarm_out |=> !pwm_enable)
    else $error("Power stage stayed on during a fault.");
  alarm_lock_a: assert property (alarm_out |=> !drive_enable_in)
    else $error("Enable was held during a fault.");
  speed_zero_a: assert property (!pwm_enable |-> speed_cmd == '0)
    else $error("Speed command without power stage.");
  pos_zero_a: assert property (mode_sel == SRS_MODE_POS && $past(mode_sel) == SRS_MODE_POS
    |-> speed_cmd == '0)
    else $error("Speed command in position mode.");

  cover property ($rose(servo_ready_out));
  cover property ($rose(pwm_enable));
  cover property ($rose(alarm_out));
  cover property (pos_step);
endmodule // srs_assertions

// ===== dv/servo_ready_enable_sequencer_bench.sv
`timescale 1ns/1ps
module servo_ready_enable_sequencer_bench;
  import srs_pkg::*;
  localparam int unsigned RC = 20;
  logic               ref_clk, rst, alarm_in, jog_fwd_key, jog_rev_key;
  logic               power_req, run_req, step_req, step_dir;
  logic [1:0]         speed_sel;
  srs_mode_t          mode_sel;
  logic               ctrl_on, main_on, pwm_enable, pos_step, pos_dir, alarm_active, restart_blocked, stop_req;
  logic signed [15:0] speed_cmd, trial_speed, jog_speed;
  int                 fails, comparisons, cyc, steps;
  srs_mode_t          md[5] = '{SRS_MODE_TRIAL, SRS_MODE_JOG, SRS_MODE_JOG, SRS_MODE_JOG, SRS_MODE_POS};
  logic [1:0]         ky[5] = '{2'h0, 2'h1, 2'h2, 2'h0, 2'h0};
  logic [15:0]        ex[5] = '{16'h0050, 16'h0070, 16'hff90, 16'h0000, 16'h0000};

  srs_if lnk();
  srs_drive #(.READY_CYCLES(RC)) i_srs_drive (.ref_clk, .rst, .link(lnk), .ctrl_power_ok(ctrl_on),
    .main_power_ok(main_on), .alarm_in, .mode_sel, .speed_presets(64'h0400_0300_0200_0100), .trial_speed,
    .jog_speed, .jog_fwd_key, .jog_rev_key, .gear_num(16'h0001), .gear_den(16'h0001), .pwm_enable,
    .speed_cmd, .pos_step, .pos_dir, .alarm_active);
  srs_ctl i_srs_ctl (.ref_clk, .rst, .link(lnk), .power_req, .run_req, .ccw_stop_req(stop_req),
    .cw_stop_req(stop_req), .speed_sel, .step_req, .step_dir, .ctrl_power_on(ctrl_on),
    .main_power_on(main_on), .restart_blocked);
  srs_assertions #(.READY_CYCLES(RC)) i_srs_assertions (.ref_clk, .rst,
    .drive_enable_in(lnk.drive_enable_in), .servo_ready_out(lnk.servo_ready_out),
    .alarm_out(lnk.alarm_out), .main_power_ok(main_on), .pwm_enable, .pos_step, .mode_sel, .speed_cmd);

  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  task automatic stop_test();
    $display("fails=%0d comparisons=%0d", fails, comparisons);
    if (fails == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Drives land on the rising edge; checks look at the falling edge that follows.
  task automatic tick(int n, bit look = 1'b0);
    repeat (n) @(posedge ref_clk);
    if (look)
      @(negedge ref_clk);
  endtask

  task automatic power_up();
    int n;
    n = 0;
    power_req <= 1'b1;
    tick(1, 1'b1);
    chk("ready_ctrl_only", lnk.servo_ready_out, 16'h0);
    chk("power_order", 16'({ctrl_on, main_on}), 16'h2);
    while (lnk.servo_ready_out !== 1'b1 && n < 100)
    begin
      @(negedge ref_clk);
      n++;
    end
    chk("ready_not_early", 16'(n >= RC), 16'h1);
    chk("ready_not_late", 16'(n <= RC + 6), 16'h1);
    chk("pwm_before_ready", pwm_enable, 16'h0);
  endtask

  always @(posedge ref_clk)
  begin
    cyc++;
    if (pos_step === 1'b1)
      steps++;
    if (cyc == 2000)
    begin
      fails++;
      stop_test();
    end
  end

  initial
  begin
    {rst, alarm_in, jog_fwd_key, jog_rev_key, power_req, run_req, step_req, step_dir, stop_req} = 9'h100;
    fails = 0;
    comparisons = 0;
    speed_sel = 2'h0;
    mode_sel = SRS_MODE_SPD;
    trial_speed = 16'h0050;
    jog_speed = 16'h0070;
    tick(2);
    rst <= 1'b0;
    tick(1, 1'b1);
    chk("idle_inputs", {lnk.ccw_inhibit_in, lnk.cw_inhibit_in, lnk.drive_enable_in}, 16'h6);
    tick(1);
    run_req <= 1'b1;
    power_up();
    for (int i = 0; i < 4; i++)
    begin
      tick(1);
      speed_sel <= i[1:0];
      tick(4, 1'b1);
      chk("speed_preset", speed_cmd, 16'(16'h0100 * (i + 1)));
    end
    tick(1);
    stop_req <= 1'b1;
    tick(3, 1'b1);
    chk("speed_inhibited", speed_cmd, 16'h0);
    tick(1);
    stop_req <= 1'b0;
    for (int i = 0; i < 5; i++)
    begin
      tick(1);
      mode_sel <= md[i];
      {jog_rev_key, jog_fwd_key} <= ky[i];
      tick(6, 1'b1);
      chk("mode_speed", speed_cmd, ex[i]);
    end
    tick(1);
    step_req <= 1'b1;
    tick(4);
    step_req <= 1'b0;
    tick(8, 1'b1);
    chk("step_count", 16'(steps), 16'h4);
    chk("step_dir", pos_dir, 16'h0);
    tick(1);
    run_req <= 1'b0;
    tick(3, 1'b1);
    chk("pwm_enable_off", pwm_enable, 16'h0);
    tick(1);
    run_req <= 1'b1;
    tick(3, 1'b1);
    chk("pwm_enable_on", pwm_enable, 16'h1);
    tick(1);
    alarm_in <= 1'b1;
    tick(6, 1'b1);
    chk("alarm_state", {pwm_enable, lnk.alarm_out, lnk.servo_ready_out}, 16'h2);
    chk("alarm_active", alarm_active, 16'h1);
    tick(1);
    alarm_in <= 1'b0;
    tick(6, 1'b1);
    chk("restart_held", {lnk.drive_enable_in, pwm_enable}, 16'h0);
    chk("restart_blocked", restart_blocked, 16'h1);
    tick(1);
    run_req <= 1'b0;
    tick(3);
    run_req <= 1'b1;
    tick(6, 1'b1);
    chk("restart_pwm", pwm_enable, 16'h1);
    tick(1);
    power_req <= 1'b0;
    tick(6, 1'b1);
    chk("ready_power_drop", {lnk.servo_ready_out, pwm_enable}, 16'h0);
    tick(1);
    power_up();
    stop_test();
  end
endmodule // servo_ready_enable_sequencer_bench
